// File: rtl/css_defs.vh
/*
 constants for the clock start-up and reset sequencer.
 assumes pclk at 100 mhz; the watchdog oscillator and the selected
 oscillator arrive as clock pins and are sampled, not used as clocks.
*/
// Notes on behaviour
// R1 - hold internal reset extra time-out after sources
// R2 - time-out in watchdog cycles: 0, 512, 8192
// R3 - oscillator-cycle counter releases reset after count
// R4 - reset: both counts; sleep wake: oscillator only
// R5 - low-power crystal range from clock_source_fuses[3:1]
// R6 - bit0=0, start time 00/01: 258 ck plus 14ck
// R7 - 1k ck cases with their reset delays
// R8 - bit0=1, start time 01..11: 16k ck cases
// R9 - rc: 6 ck wake, 14 ck plus delay
// R10 - clock_source_fuses 0010 selects calibrated rc
// R11 - calibration byte copied to trim during reset
// R12 - time-out always timed from watchdog oscillator
// R13 - divide_by_eight_fuse programmed divides clock by 8
// R14 - unprogrammed fuse resets prescaler field to 0000
// R15 - fuses sampled before time-out, then held
`ifndef CSS_DEFS_VH
`define CSS_DEFS_VH
`define CSS_ADDR_CTRL 12'h000
`define CSS_ADDR_STAT 12'h004
`define CSS_ADDR_TRIM 12'h008
`define CSS_ADDR_FUSE 12'h00c
`define CSS_TOUT_NONE 14'h0000
`define CSS_TOUT_4MS 14'h0200
`define CSS_TOUT_65MS 14'h2000
`define CSS_EXTRA_CK 15'h000e
`define CSS_SU_6 15'h0006
`define CSS_SU_258 15'h0102
`define CSS_SU_1K 15'h0400
`define CSS_SU_16K 15'h4000
`define CSS_SRC_RC 4'h2
`define CSS_SRC_EXT 4'h0
`define CSS_PS_UNDIV 4'h0
`define CSS_PS_DIV8 4'h3
`define CSS_DIV8_LAST 3'h7
`define CSS_MODE_XTAL 2'h0
`define CSS_MODE_RC 2'h1
`define CSS_MODE_EXT 2'h2
`define CSS_MODE_BAD 2'h3
`endif

// File: rtl/css_edge.v
/*
 sync and rising-edge detect of one outside clock pin.
 assumes pclk is much faster than the pin clock.
*/
`timescale 1ns/100ps
module css_edge
(
   input wire pclk,
   input wire presetn,
   input wire pin,
   output wire rise
);
reg s1_q;
reg s2_q;
reg s3_q;
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
   end
   else
   begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
   end
end
assign rise = s2_q & ~s3_q;
endmodule // css_edge

// File: rtl/css_top.v
/*
 start-up sequencer: holds internal reset through the watchdog time-out
 and the oscillator start-up count, decodes fuses, loads rc trim and
 prescaler, apb slave for status.
 assumes fuses, calibration byte and reset sources are static levels
 from outside the pclk domain.
*/
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
`include "css_defs.vh"
module css_top
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire ext_reset_active,
   input wire wake_from_sleep,
   input wire wdt_osc_clk,
   input wire sel_osc_clk,
   input wire [3:0] clock_source_fuses,
   input wire [1:0] start_time_fuses,
   input wire divide_by_eight_fuse,
   input wire [7:0] calibration_byte,
   output wire internal_reset,
   output wire sys_clk_en,
   output wire rc_select,
   output wire [7:0] rc_trim_register,
   output wire [3:0] prescaler_select_field,
   output wire [1:0] xtal_range
);

// ****************************************
// state and synchronisers
// ****************************************
localparam ST_HOLD = 3'h0;
localparam ST_SAMPLE = 3'h1;
localparam ST_TOUT = 3'h2;
localparam ST_START = 3'h3;
localparam ST_RUN = 3'h4;

reg [2:0] st_q;
reg [2:0] st_d;
reg [13:0] wdt_cnt_q;
reg [13:0] wdt_cnt_d;
reg [14:0] osc_cnt_q;
reg [14:0] osc_cnt_d;
reg [3:0] cks_q;
reg [1:0] stime_q;
reg div8_q;
reg [7:0] trim_q;
reg [3:0] ps_q;
reg [2:0] div_q;
reg [3:0] ctrl_q;
reg rst_s1_q;
reg rst_s2_q;
reg wake_s1_q;
reg wake_s2_q;
reg wake_s3_q;
reg [3:0] fcks_s1_q;
reg [3:0] fcks_s2_q;
reg [1:0] fst_s1_q;
reg [1:0] fst_s2_q;
reg fdiv_s1_q;
reg fdiv_s2_q;
reg [7:0] cal_s1_q;
reg [7:0] cal_s2_q;
wire wdt_rise;
wire osc_rise;
wire wake_pulse;
wire apb_wr;
reg [31:0] rdata;
reg [13:0] tout_len;
reg [14:0] su_len;
reg [14:0] extra_len;
reg [1:0] mode;

always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= 1'b1;
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
      wake_s3_q <= 1'b0;
      fcks_s1_q <= `CSS_SRC_EXT;
      fcks_s2_q <= `CSS_SRC_EXT;
      fst_s1_q <= 2'h0;
      fst_s2_q <= 2'h0;
      fdiv_s1_q <= 1'b1;
      fdiv_s2_q <= 1'b1;
      cal_s1_q <= 8'h00;
      cal_s2_q <= 8'h00;
   end
   else
   begin
      rst_s1_q <= ext_reset_active;
      rst_s2_q <= rst_s1_q;
      wake_s1_q <= wake_from_sleep;
      wake_s2_q <= wake_s1_q;
      wake_s3_q <= wake_s2_q;
      fcks_s1_q <= clock_source_fuses;
      fcks_s2_q <= fcks_s1_q;
      fst_s1_q <= start_time_fuses;
      fst_s2_q <= fst_s1_q;
      fdiv_s1_q <= divide_by_eight_fuse;
      fdiv_s2_q <= fdiv_s1_q;
      cal_s1_q <= calibration_byte;
      cal_s2_q <= cal_s1_q;
   end
end
assign wake_pulse = wake_s2_q & ~wake_s3_q;

// watchdog oscillator times the time-out, whatever clocks the core
css_edge u_wdt_edge
(
   .pclk(pclk),
   .presetn(presetn),
   .pin(wdt_osc_clk),
   .rise(wdt_rise)
); // [R12]

css_edge u_osc_edge
(
   .pclk(pclk),
   .presetn(presetn),
   .pin(sel_osc_clk),
   .rise(osc_rise)
);

// ****************************************
// fuse decode
// ****************************************
always @*
begin
   if (cks_q[3])
      mode = `CSS_MODE_XTAL;
   else if (cks_q == `CSS_SRC_RC) // [R10]
      mode = `CSS_MODE_RC;
   else if (cks_q == `CSS_SRC_EXT)
      mode = `CSS_MODE_EXT;
   else
      mode = `CSS_MODE_BAD;
end

always @*
begin
   tout_len = `CSS_TOUT_NONE;
   su_len = `CSS_SU_6;
   extra_len = `CSS_EXTRA_CK;
   if (mode == `CSS_MODE_XTAL)
   begin
      case ({cks_q[0], stime_q})
         3'b000: su_len = `CSS_SU_258; // [R6]
         3'b001: su_len = `CSS_SU_258; // [R6]
         3'b010: su_len = `CSS_SU_1K; // [R7]
         3'b011: su_len = `CSS_SU_1K; // [R7]
         3'b100: su_len = `CSS_SU_1K; // [R7]
         default: su_len = `CSS_SU_16K; // [R8]
      endcase
      case ({cks_q[0], stime_q})
         3'b000: tout_len = `CSS_TOUT_4MS; // [R6]
         3'b001: tout_len = `CSS_TOUT_65MS; // [R6]
         3'b011: tout_len = `CSS_TOUT_4MS; // [R7]
         3'b100: tout_len = `CSS_TOUT_65MS; // [R7]
         3'b110: tout_len = `CSS_TOUT_4MS; // [R8]
         3'b111: tout_len = `CSS_TOUT_65MS; // [R8]
         default: tout_len = `CSS_TOUT_NONE; // [R7] [R8]
      endcase
   end
   else
   begin
      // rc and external clock: 6 ck wake; reserved 11 taken as longest
      case (stime_q)
         2'b00: tout_len = `CSS_TOUT_NONE; // [R9]
         2'b01: tout_len = `CSS_TOUT_4MS; // [R9]
         default: tout_len = `CSS_TOUT_65MS; // [R9]
      endcase
   end
   // [R2] time-out lengths above are watchdog cycles; start-up lengths are oscillator cycles
end

assign rc_select = (mode == `CSS_MODE_RC); // [R10]
assign xtal_range = (mode == `CSS_MODE_XTAL) ? cks_q[2:1] : 2'h0; // [R5]

// ****************************************
// sequencer
// ****************************************
always @*
begin
   st_d = st_q;
   wdt_cnt_d = wdt_cnt_q;
   osc_cnt_d = osc_cnt_q;
   case (st_q)
      ST_HOLD:
         if (!rst_s2_q)
            st_d = ST_SAMPLE; // [R1]
      ST_SAMPLE:
      begin
         st_d = ST_TOUT; // [R15]
         wdt_cnt_d = 14'h0000;
      end
      ST_TOUT:
         if (wdt_cnt_q >= tout_len) // [R1]
         begin
            st_d = ST_START;
            osc_cnt_d = 15'h0000;
         end
         else if (wdt_rise)
            wdt_cnt_d = wdt_cnt_q + 14'h0001; // [R2]
      ST_START:
         // from reset the 14 ck extra delay follows the start-up count
         if (osc_cnt_q >= su_len + (wake_s2_q ? 15'h0000 : extra_len))
            st_d = ST_RUN; // [R3]
         else if (osc_rise)
            osc_cnt_d = osc_cnt_q + 15'h0001; // [R3]
      ST_RUN:
         if (wake_pulse)
         begin
            st_d = ST_START; // [R4]
            osc_cnt_d = 15'h0000;
         end
      default:
         st_d = ST_HOLD;
   endcase
   if (rst_s2_q)
      st_d = ST_HOLD;
end

always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      st_q <= ST_HOLD;
      wdt_cnt_q <= 14'h0000;
      osc_cnt_q <= 15'h0000;
      cks_q <= `CSS_SRC_EXT;
      stime_q <= 2'h0;
      div8_q <= 1'b1;
      trim_q <= 8'h00;
      ps_q <= `CSS_PS_UNDIV;
   end
   else
   begin
      st_q <= st_d;
      wdt_cnt_q <= wdt_cnt_d;
      osc_cnt_q <= osc_cnt_d;
      if (st_q == ST_HOLD || st_q == ST_SAMPLE)
      begin
         cks_q <= fcks_s2_q; // [R15]
         stime_q <= fst_s2_q; // [R15]
         div8_q <= fdiv_s2_q;
         trim_q <= cal_s2_q; // [R11]
         // fuse low means programmed
         ps_q <= fdiv_s2_q ? `CSS_PS_UNDIV : `CSS_PS_DIV8; // [R13] [R14]
      end
      else if (apb_wr && paddr == `CSS_ADDR_TRIM)
         trim_q <= pwdata[7:0];
   end
end

assign internal_reset = (st_q != ST_RUN); // [R1] [R3]

// ****************************************
// system clock divider
// ****************************************
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
      div_q <= 3'h0;
   else if (internal_reset)
      div_q <= 3'h0;
   else if (osc_rise)
      div_q <= div_q + 3'h1;
end

// one enable per oscillator cycle, or per eight when divided
assign sys_clk_en = ~internal_reset & osc_rise &
   (div8_q | (div_q == `CSS_DIV8_LAST)); // [R13]
assign rc_trim_register = trim_q;
assign prescaler_select_field = ps_q;

// ****************************************
// apb slave
// ****************************************
assign apb_wr = psel & penable & pwrite;
assign pready = 1'b1;
assign pslverr = psel & penable & ~((paddr == `CSS_ADDR_CTRL) |
   (paddr == `CSS_ADDR_STAT) | (paddr == `CSS_ADDR_TRIM) |
   (paddr == `CSS_ADDR_FUSE));

always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
      ctrl_q <= 4'h0;
   else if (apb_wr && paddr == `CSS_ADDR_CTRL)
      ctrl_q <= pwdata[3:0];
end

always @*
begin
   if (paddr == `CSS_ADDR_CTRL)
      rdata = {28'h0000000, ctrl_q};
   else if (paddr == `CSS_ADDR_STAT)
      rdata = {25'h0000000, mode, internal_reset, st_q, rc_select};
   else if (paddr == `CSS_ADDR_TRIM)
      rdata = {24'h000000, trim_q};
   else if (paddr == `CSS_ADDR_FUSE)
      rdata = {21'h000000, ps_q, div8_q, stime_q, cks_q};
   else
      rdata = 32'h00000000;
end
assign prdata = rdata;
endmodule // css_top

// File: sim/css_tb_top.sv
/*
 self-checking bench for the start-up sequencer.
 assumes the checker is bound by its own file.
*/
`timescale 1ns/100ps
module clock_startup_reset_sequencer_tb_top;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic ext = 1, wake = 0, wdt = 0, osc = 0, div8 = 0, er;
   logic pready, pslverr, irst, clk_en, rcs;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [3:0] cks = 4'h2, ps;
   logic [1:0] stf = 0, xr;
   logic [7:0] cal = 8'h5a, trim;
   int failures = 0, n_checks = 0, cyc = 0;
   // watchdog 4 pclk per cycle, oscillator 2 pclk per cycle
   always #5 pclk = ~pclk;
   always #20 wdt = ~wdt;
   always #10 osc = ~osc;
   css_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_reset_active(ext), .wake_from_sleep(wake), .wdt_osc_clk(wdt),
      .sel_osc_clk(osc), .clock_source_fuses(cks), .start_time_fuses(stf),
      .divide_by_eight_fuse(div8), .calibration_byte(cal),
      .internal_reset(irst), .sys_clk_en(clk_en), .rc_select(rcs),
      .rc_trim_register(trim), .prescaler_select_field(ps),
      .xtal_range(xr));
   // ****************
   // helpers
   // ****************
   task tally_and_finish;
      $display("checks=%0d failures=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         failures++;
         tally_and_finish;
      end
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e)
      begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // counts drift by sync and edge phase, hence the window
   task near(input int g, input int e, input int t);
      n_checks++;
      if (g < e - t || g > e + t)
      begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task boot(input logic [3:0] c, input logic [1:0] s, input logic d,
      input int len, input int ne);
      int l, n;
      l = 0;
      n = 0;
      ext <= 1;
      repeat (4) @(posedge pclk);
      cks <= c;
      stf <= s;
      div8 <= d;
      repeat (4) @(posedge pclk);
      ext <= 0;
      do
      begin
         @(posedge pclk);
         l++;
      end
      while (irst !== 1'b0 && l < 40000);
      near(l, len, 14);
      repeat (64) @(posedge pclk) n += (clk_en === 1'b1);
      near(n, ne, 1);
      chk(ps, d ? 4'h0 : 4'h3);
      chk(rcs, c == 4'h2);
      chk(xr, c[3] ? c[2:1] : 2'h0);
      chk(trim, cal);
      $display("boot %h %h done", c, s);
   endtask
   // ****************
   // scenarios
   // ****************
   task t_rc;
      boot(4'h0, 2'h0, 1'b1, 40, 32);
      boot(4'h2, 2'h0, 1'b0, 40, 4);
      boot(4'h2, 2'h1, 1'b1, 2088, 32);
   endtask
   task t_apb;
      apb(0, 12'h008, 0);
      chk(rd, {24'h0, cal});
      apb(1, 12'h008, 32'h3c);
      chk(trim, 8'h3c);
      apb(0, 12'h00c, 0);
      chk(rd, 32'h52);
      apb(0, 12'h004, 0);
      chk(rd, 32'h29);
      apb(1, 12'h000, 32'h5);
      apb(0, 12'h000, 0);
      chk(rd, 32'h5);
      apb(0, 12'h010, 0);
      chk(er, 1'b1);
      chk(rd, 32'h0);
      $display("apb done");
   endtask
   task t_wake;
      int l;
      logic seen;
      l = 0;
      seen = 0;
      wake <= 1;
      do
      begin
         @(posedge pclk);
         l++;
         seen |= irst;
      end
      while (!(seen && irst === 1'b0) && l < 3000);
      chk(seen, 1'b1);
      near(l, 12, 14);
      wake <= 0;
      @(posedge pclk);
      $display("wake done");
   endtask
   task t_xtal;
      boot(4'h8, 2'h0, 1'b1, 2592, 32);
      boot(4'hc, 2'h2, 1'b1, 2076, 32);
      boot(4'hd, 2'h1, 1'b0, 32796, 4);
   endtask
   initial
   begin
      repeat (3) @(posedge pclk);
      presetn <= 1;
      t_rc;
      t_apb;
      t_wake;
      t_xtal;
      tally_and_finish;
   end
endmodule // clock_startup_reset_sequencer_tb_top

// File: sim/css_top_monitor.sv
/*
 checker for the start-up sequencer top ports.
 assumes bind into css_top, one pclk domain.
*/
`timescale 1ns/100ps
module css_top_chk
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire [11:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire ext_reset_active,
   input wire wake_from_sleep,
   input wire [3:0] clock_source_fuses,
   input wire divide_by_eight_fuse,
   input wire [7:0] calibration_byte,
   input wire internal_reset,
   input wire sys_clk_en,
   input wire rc_select,
   input wire [7:0] rc_trim_register,
   input wire [3:0] prescaler_select_field,
   input wire [1:0] xtal_range
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire acc = psel && penable;
   wire map = paddr < 12'h010 && paddr[1:0] == 2'b00;
   wire [3:0] cks = clock_source_fuses;
   // ****************
   // assertions
   // ****************
   property p_hold; ext_reset_active [*4] |-> internal_reset; endproperty
   a_hold: assert property (p_hold)
      else $error("reset not held");
   property p_rel;
      $fell(internal_reset) |->
         !ext_reset_active && !$past(ext_reset_active, 3);
   endproperty
   a_rel: assert property (p_rel)
      else $error("early release");
   // divided enable: eight oscillator rises apart, at least nine pclk
   property p_gate;
      sys_clk_en && !divide_by_eight_fuse |=> !sys_clk_en [*8];
   endproperty
   a_gate: assert property (p_gate)
      else $error("divided clock enable too dense");
   property p_wake;
      $rose(wake_from_sleep) && !internal_reset && !ext_reset_active
         |-> ##[1:6] internal_reset;
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake did not restart count");
   property p_rc; !internal_reset |-> rc_select == (cks == 4'h2); endproperty
   a_rc: assert property (p_rc)
      else $error("rc select wrong");
   property p_rng;
      !internal_reset |-> xtal_range == (cks[3] ? cks[2:1] : 2'h0);
   endproperty
   a_rng: assert property (p_rng)
      else $error("crystal range wrong");
   property p_ps;
      !internal_reset |-> prescaler_select_field ==
         (divide_by_eight_fuse ? 4'h0 : 4'h3);
   endproperty
   a_ps: assert property (p_ps)
      else $error("prescaler wrong");
   property p_trim;
      $fell(internal_reset) && !wake_from_sleep
         |-> rc_trim_register == calibration_byte;
   endproperty
   a_trim: assert property (p_trim)
      else $error("trim not loaded");
   property p_err; acc && !map |-> pslverr && prdata == 32'h0; endproperty
   a_err: assert property (p_err)
      else $error("unmapped access not refused");
   property p_ok; acc && map |-> pready && !pslverr; endproperty
   a_ok: assert property (p_ok)
      else $error("mapped access refused");
   c_rel: cover property ($fell(internal_reset));
   c_wake: cover property ($rose(internal_reset) && wake_from_sleep);
   c_err: cover property (acc && pslverr);
endmodule // css_top_chk

bind css_top css_top_chk i_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .ext_reset_active(ext_reset_active),
   .wake_from_sleep(wake_from_sleep), .clock_source_fuses(clock_source_fuses),
   .divide_by_eight_fuse(divide_by_eight_fuse),
   .calibration_byte(calibration_byte), .internal_reset(internal_reset),
   .sys_clk_en(sys_clk_en), .rc_select(rc_select),
   .rc_trim_register(rc_trim_register),
   .prescaler_select_field(prescaler_select_field), .xtal_range(xtal_range));
